// ### hdl/sacc_pkg.sv
/*
  Package for the converter control block: field widths, mode codes, clock
  source codes, timing counts and the packed configuration carrier.
  Assumes a single 25 MHz control clock; sacc_top and the bench depend on it.
*/
package sacc_pkg;

  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned CHAN_W          = 5;
  localparam int unsigned RAW_W           = 12;
  localparam int unsigned PIN_COUNT       = 16;
  localparam int unsigned FIFO_MAX        = 8;
  localparam int unsigned FIFO_PTR_W      = 3;

  // Channel code that switches the converter off
  localparam logic [4:0]  CHAN_OFF        = 5'h1F;

  // Resolution codes
  localparam logic [1:0]  MODE_8BIT       = 2'h0;
  localparam logic [1:0]  MODE_12BIT      = 2'h1;
  localparam logic [1:0]  MODE_10BIT      = 2'h2;

  // Clock source codes; bus clock is the reset default
  localparam logic [1:0]  SRC_BUS         = 2'h0;
  localparam logic [1:0]  SRC_BUS_HALF    = 2'h1;
  localparam logic [1:0]  SRC_ALT         = 2'h2;
  localparam logic [1:0]  SRC_ASYNC       = 2'h3;

  // Sample phase length in converter clock ticks, less one, and internal oscillator period
  localparam logic [4:0]  SAMPLE_TICKS    = 5'h04;
  localparam int unsigned ASYNC_PERIOD_NS = 200;
  localparam int unsigned ASYNC_CYCLES    = (ASYNC_PERIOD_NS * (CLK_HZ / 1000000)) / 1000;

  // Reset values
  localparam logic [7:0]  RESULT_RESET    = 8'h00;
  localparam logic [3:0]  BIT_IDX_TOP     = 4'hB;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_SAMPLE  = 2'b01,
    ST_CONVERT = 2'b10,
    ST_FINISH  = 2'b11
  } sacc_state_e;

  typedef struct packed {
    logic [4:0] channel_select;
    logic       done_interrupt_enable;
    logic       compare_enable;
    logic       compare_greater;
    logic       hw_trigger_enable;
    logic       continuous_enable;
    logic [1:0] mode;
    logic [1:0] clock_source_select;
    logic [1:0] clock_divide_select;
    logic [2:0] fifo_depth;
  } sacc_cfg_s;

endpackage

// ### hdl/sacc_top.sv
/*
  Successive-approximation converter control: clock select and divide, pin
  isolation, software and hardware triggers, single and continuous runs,
  12/10/8-bit results with rounding, done flag, interrupt and read blocking.
  Assumes the analog core returns its comparator decision on COMP_IN within
  one converter tick; HW_TRIG, ALT_CLK and PORT_IN are asynchronous pins.
*/
`timescale 1ns/1ps
module sacc_top #(
  parameter int unsigned ASYNC_CYCLES = sacc_pkg::ASYNC_CYCLES
) (
  input  wire logic                  MCLK,
  input  wire logic                  RST,
  input  wire sacc_pkg::sacc_cfg_s   CFG,
  input  wire logic                  SC1_WR,
  input  wire logic                  CFG_WR,
  input  wire logic [11:0]           CMP_VALUE,
  input  wire logic                  DONE_CLEAR,
  input  wire logic                  RH_READ,
  input  wire logic                  RL_READ,
  input  wire logic                  LOW_POWER,
  input  wire logic                  ALT_CLK,
  input  wire logic                  HW_TRIG,
  input  wire logic                  COMP_IN,
  input  wire logic [15:0]           PIN_CTRL,
  input  wire logic [15:0]           PORT_IN,
  output logic [15:0]                PORT_READ,
  output logic [15:0]                PIN_OUT_DISABLE,
  output logic [15:0]                PULLUP_DISABLE,
  output logic                       CORE_ENABLE,
  output logic                       SAMPLE,
  output logic [4:0]                 CHANNEL,
  output logic [11:0]                DAC_CODE,
  output logic                       ADCK_TICK,
  output logic [7:0]                 RESULT_HIGH,
  output logic [7:0]                 RESULT_LOW,
  output logic                       DONE_FLAG,
  output logic                       IRQ,
  output logic                       BUSY
);

  sacc_pkg::sacc_state_e state_reg;
  sacc_pkg::sacc_state_e state_next;

  logic [1:0]  trig_sync_reg;
  logic        trig_last_reg;
  logic [1:0]  alt_sync_reg;
  logic        alt_last_reg;
  logic [15:0] port_s1_reg;
  logic [15:0] port_s2_reg;
  logic        half_reg;
  logic [15:0] async_cnt_reg;
  logic [2:0]  div_cnt_reg;
  logic [4:0]  samp_cnt_reg;
  logic [3:0]  bit_idx_reg;
  logic [11:0] sar_reg;
  logic [4:0]  chan_reg;
  logic        cont_run_reg;
  logic        read_pend_reg;
  logic        done_reg;
  logic [7:0]  rh_reg;
  logic [7:0]  rl_reg;
  logic [4:0]  chan_mem [sacc_pkg::FIFO_MAX];
  logic [2:0]  fill_reg;
  logic [2:0]  conv_idx_reg;
  logic [7:0]  res_hi_mem [sacc_pkg::FIFO_MAX];
  logic [7:0]  res_lo_mem [sacc_pkg::FIFO_MAX];
  logic [2:0]  rd_idx_reg;

  // Clock generation
  wire trig_rise   = trig_sync_reg[1] & ~trig_last_reg;
  wire alt_rise    = alt_sync_reg[1] & ~alt_last_reg;
  wire async_tick  = (async_cnt_reg == 16'(ASYNC_CYCLES - 1));
  wire run_gate    = ~LOW_POWER | (CFG.clock_source_select == sacc_pkg::SRC_ASYNC);
  logic src_tick;
  always_comb begin
    case (CFG.clock_source_select)
      sacc_pkg::SRC_BUS:      src_tick = 1'b1;
      sacc_pkg::SRC_BUS_HALF: src_tick = half_reg;
      sacc_pkg::SRC_ALT:      src_tick = alt_rise;
      sacc_pkg::SRC_ASYNC:    src_tick = async_tick;
      default:                src_tick = 1'b1;
    endcase
  end
  wire [2:0] div_top  = 3'((4'h1 << CFG.clock_divide_select) - 4'h1);
  wire       active   = (state_reg != sacc_pkg::ST_IDLE);
  wire       src_gate = src_tick & run_gate & active;
  wire       adck     = src_gate & (div_cnt_reg == div_top);

  // Control decode
  wire disabled    = (CFG.channel_select == sacc_pkg::CHAN_OFF);
  wire fifo_mode   = (CFG.fifo_depth != 3'h0);
  wire fifo_filled = SC1_WR & fifo_mode & ~disabled & (fill_reg == CFG.fifo_depth);
  wire sw_start    = SC1_WR & ~disabled & ~CFG.hw_trigger_enable & (~fifo_mode | fifo_filled);
  wire hw_start    = trig_rise & CFG.hw_trigger_enable & ~disabled & ~active & ~cont_run_reg;
  wire start       = sw_start | hw_start;
  wire abort       = CFG_WR | SC1_WR | disabled;

  // Result shaping
  wire [12:0] r10    = {1'b0, sar_reg} + 13'h0002;
  wire [12:0] r8     = {1'b0, sar_reg} + 13'h0008;
  logic [11:0] shaped;
  always_comb begin
    case (CFG.mode)
      sacc_pkg::MODE_12BIT: shaped = sar_reg;
      sacc_pkg::MODE_10BIT: shaped = r10[12] ? 12'h3FF : {2'h0, r10[11:2]};
      sacc_pkg::MODE_8BIT:  shaped = r8[12] ? 12'h0FF : {4'h0, r8[11:4]};
      default:              shaped = sar_reg;
    endcase
  end
  wire cmp_ok   = CFG.compare_greater ? (shaped >= CMP_VALUE) : (shaped < CMP_VALUE);
  wire cmp_fail = CFG.compare_enable & ~cmp_ok;
  wire wide     = (CFG.mode != sacc_pkg::MODE_8BIT);
  wire blocked  = read_pend_reg & wide;
  wire fin      = (state_reg == sacc_pkg::ST_FINISH);
  wire fifo_last = (conv_idx_reg == CFG.fifo_depth);
  // Compare-false single run ends with no transfer and no retry
  wire end_quiet = fin & cmp_fail & ~fifo_mode & ~CFG.continuous_enable;
  wire transfer  = fin & ~blocked & (~cmp_fail | fifo_mode);
  wire retry     = fin & blocked & ~end_quiet;
  wire next_conv = fin & ~end_quiet & (retry | (fifo_mode ? ~fifo_last : CFG.continuous_enable) |
                                      (~fifo_mode & cmp_fail & CFG.continuous_enable));
  wire fifo_done = transfer & fifo_mode & fifo_last;
  wire set_done  = transfer & (~fifo_mode | fifo_done);
  wire [7:0] new_hi = wide ? {4'h0, shaped[11:8]} : sacc_pkg::RESULT_RESET;
  wire [7:0] new_lo = shaped[7:0];

  // Sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sacc_pkg::ST_IDLE:    if (start) state_next = sacc_pkg::ST_SAMPLE;
      sacc_pkg::ST_SAMPLE:  if (adck && samp_cnt_reg == sacc_pkg::SAMPLE_TICKS) state_next = sacc_pkg::ST_CONVERT;
      sacc_pkg::ST_CONVERT: if (adck && bit_idx_reg == 4'h0) state_next = sacc_pkg::ST_FINISH;
      sacc_pkg::ST_FINISH:  state_next = next_conv ? sacc_pkg::ST_SAMPLE : sacc_pkg::ST_IDLE;
      default:              state_next = sacc_pkg::ST_IDLE;
    endcase
    if (abort && !start) begin
      state_next = sacc_pkg::ST_IDLE;
    end
    if (abort && start) begin
      state_next = sacc_pkg::ST_SAMPLE;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      state_reg <= sacc_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Synchronisers: first stage feeds only the second
  always_ff @(posedge MCLK) begin
    if (RST) begin
      trig_sync_reg <= 2'h0;
      trig_last_reg <= 1'b0;
      alt_sync_reg  <= 2'h0;
      alt_last_reg  <= 1'b0;
      port_s1_reg   <= 16'h0000;
      port_s2_reg   <= 16'h0000;
    end else begin
      trig_sync_reg <= {trig_sync_reg[0], HW_TRIG};
      trig_last_reg <= trig_sync_reg[1];
      alt_sync_reg  <= {alt_sync_reg[0], ALT_CLK};
      alt_last_reg  <= alt_sync_reg[1];
      port_s1_reg   <= PORT_IN;
      port_s2_reg   <= port_s1_reg;
    end
  end

  // Clock counters run only while converting, so idle draws least
  always_ff @(posedge MCLK) begin
    if (RST) begin
      half_reg      <= 1'b0;
      async_cnt_reg <= 16'h0000;
      div_cnt_reg   <= 3'h0;
    end else begin
      half_reg      <= active & ~half_reg;
      async_cnt_reg <= (~active | async_tick) ? 16'h0000 : async_cnt_reg + 16'h0001;
      div_cnt_reg   <= ~active ? 3'h0 : (adck ? 3'h0 : (src_gate ? div_cnt_reg + 3'h1 : div_cnt_reg));
    end
  end

  // Successive approximation, MSB first
  always_ff @(posedge MCLK) begin
    if (RST) begin
      samp_cnt_reg <= 5'h00;
      bit_idx_reg  <= sacc_pkg::BIT_IDX_TOP;
      sar_reg      <= 12'h000;
    end else if (state_next == sacc_pkg::ST_SAMPLE && state_reg != sacc_pkg::ST_SAMPLE) begin
      samp_cnt_reg <= 5'h00;
      bit_idx_reg  <= sacc_pkg::BIT_IDX_TOP;
      sar_reg      <= 12'h800;
    end else if (adck && state_reg == sacc_pkg::ST_SAMPLE) begin
      samp_cnt_reg <= samp_cnt_reg + 5'h01;
    end else if (adck && state_reg == sacc_pkg::ST_CONVERT) begin
      sar_reg[bit_idx_reg] <= COMP_IN;
      if (bit_idx_reg != 4'h0) begin
        sar_reg[bit_idx_reg - 4'h1] <= 1'b1;
        bit_idx_reg <= bit_idx_reg - 4'h1;
      end
    end
  end

  // Channel FIFO and channel in use
  always_ff @(posedge MCLK) begin
    if (RST) begin
      fill_reg     <= 3'h0;
      conv_idx_reg <= 3'h0;
      chan_reg     <= sacc_pkg::CHAN_OFF;
    end else begin
      if (CFG_WR) begin
        fill_reg <= 3'h0;
      end else if (SC1_WR && fifo_mode && !disabled) begin
        chan_mem[fill_reg] <= CFG.channel_select;
        fill_reg           <= fifo_filled ? 3'h0 : fill_reg + 3'h1;
      end
      if (sw_start && !fifo_mode) begin
        chan_reg <= CFG.channel_select;
      end else if (sw_start || hw_start) begin
        conv_idx_reg <= 3'h0;
        chan_reg     <= fifo_filled ? chan_mem[0] : (fifo_mode ? chan_mem[0] : CFG.channel_select);
      end else if (fin && fifo_mode && !retry && !fifo_last) begin
        conv_idx_reg <= conv_idx_reg + 3'h1;
        chan_reg     <= chan_mem[conv_idx_reg + 3'h1];
      end
      if (fifo_filled) begin
        chan_mem[fill_reg] <= CFG.channel_select;
      end
    end
  end

  // Continuous run tracking for the hardware trigger
  always_ff @(posedge MCLK) begin
    if (RST) begin
      cont_run_reg <= 1'b0;
    end else if (abort) begin
      cont_run_reg <= 1'b0;
    end else if (hw_start && CFG.continuous_enable) begin
      cont_run_reg <= 1'b1;
    end
  end

  // Result registers, done flag and read blocking
  always_ff @(posedge MCLK) begin
    if (RST) begin
      rh_reg        <= sacc_pkg::RESULT_RESET;
      rl_reg        <= sacc_pkg::RESULT_RESET;
      read_pend_reg <= 1'b0;
      done_reg      <= 1'b0;
      rd_idx_reg    <= 3'h0;
    end else begin
      if (RL_READ) begin
        read_pend_reg <= 1'b0;
      end else if (RH_READ && wide) begin
        read_pend_reg <= 1'b1;
      end
      // A new done wins over a clear in the same cycle
      if (set_done) begin
        done_reg <= 1'b1;
      end else if (DONE_CLEAR || SC1_WR || CFG_WR) begin
        done_reg <= 1'b0;
      end
      if (transfer && fifo_mode) begin
        res_hi_mem[conv_idx_reg] <= new_hi;
        res_lo_mem[conv_idx_reg] <= new_lo;
      end
      if (transfer && !fifo_mode) begin
        rh_reg <= new_hi;
        rl_reg <= new_lo;
      end else if (fifo_done) begin
        rh_reg     <= (conv_idx_reg == 3'h0) ? new_hi : res_hi_mem[0];
        rl_reg     <= (conv_idx_reg == 3'h0) ? new_lo : res_lo_mem[0];
        rd_idx_reg <= 3'h1;
      end else if (RL_READ && fifo_mode && rd_idx_reg <= CFG.fifo_depth && rd_idx_reg != 3'h0) begin
        rh_reg     <= res_hi_mem[rd_idx_reg];
        rl_reg     <= res_lo_mem[rd_idx_reg];
        rd_idx_reg <= rd_idx_reg + 3'h1;
      end
    end
  end

  // Pin isolation and outputs
  assign PORT_READ       = port_s2_reg & ~PIN_CTRL;
  assign PIN_OUT_DISABLE = PIN_CTRL;
  assign PULLUP_DISABLE  = PIN_CTRL;
  assign CORE_ENABLE     = active & ~disabled;
  assign SAMPLE          = (state_reg == sacc_pkg::ST_SAMPLE);
  assign CHANNEL         = chan_reg;
  assign DAC_CODE        = sar_reg;
  assign ADCK_TICK       = adck;
  assign RESULT_HIGH     = rh_reg;
  assign RESULT_LOW      = rl_reg;
  assign DONE_FLAG       = done_reg;
  assign IRQ             = done_reg & CFG.done_interrupt_enable;
  assign BUSY            = active;

  // Assertions
  reset_idle_a: assert property (@(posedge MCLK) RST |=> state_reg == sacc_pkg::ST_IDLE)
    else $error("not idle after reset");
  off_channel_a: assert property (@(posedge MCLK) disable iff (RST)
    disabled |=> !SAMPLE && state_reg == sacc_pkg::ST_IDLE)
    else $error("active while channel off");
  idle_quiet_a: assert property (@(posedge MCLK) disable iff (RST) !BUSY |-> !ADCK_TICK)
    else $error("converter clock runs while idle");
  irq_done_a: assert property (@(posedge MCLK) disable iff (RST)
    $rose(DONE_FLAG) && CFG.done_interrupt_enable |-> IRQ)
    else $error("interrupt missing on done");
  block_drop_a: assert property (@(posedge MCLK) disable iff (RST)
    fin && blocked && !DONE_FLAG |=> !DONE_FLAG && $stable(RESULT_LOW))
    else $error("blocked result was transferred");
  hw_busy_a: assert property (@(posedge MCLK) disable iff (RST)
    BUSY && !fin && trig_rise && !SC1_WR && !CFG_WR |=> BUSY && !$rose(SAMPLE))
    else $error("trigger restarted busy converter");
  hw_start_a: assert property (@(posedge MCLK) disable iff (RST)
    hw_start && !abort |=> SAMPLE)
    else $error("hardware trigger ignored");
  cfg_abort_a: assert property (@(posedge MCLK) disable iff (RST)
    CFG_WR && !sw_start |=> !BUSY && $stable(RESULT_LOW) && $stable(RESULT_HIGH))
    else $error("configuration write did not abort");
  narrow_hi_a: assert property (@(posedge MCLK) disable iff (RST)
    transfer && !fifo_mode && CFG.mode == sacc_pkg::MODE_8BIT |=> RESULT_HIGH == 8'h00)
    else $error("narrow result reached high register");
  ten_range_a: assert property (@(posedge MCLK) disable iff (RST)
    transfer && !fifo_mode && CFG.mode == sacc_pkg::MODE_10BIT |=> RESULT_HIGH[7:2] == 6'h00)
    else $error("ten-bit result out of range");
  retry_a: assert property (@(posedge MCLK) disable iff (RST)
    retry && !abort |=> SAMPLE)
    else $error("blocked conversion not restarted");

  done_cov_c: cover property (@(posedge MCLK) disable iff (RST) $rose(DONE_FLAG));
  block_cov_c: cover property (@(posedge MCLK) disable iff (RST) retry);
  cont_cov_c: cover property (@(posedge MCLK) disable iff (RST) fin && next_conv && !retry);

endmodule

// ### sim/sacc_core_model.sv
/*
  Stand-in for the analog core and the on-chip trigger source: a comparator
  against a held input level, and an asynchronous trigger pulse on request.
  Assumes the bench sets the level and requests triggers through fire.
*/
`timescale 1ns/1ps
module sacc_core_model (
  input  wire logic        mclk,
  input  wire logic        core_en,
  input  wire logic [11:0] dac_code,
  input  wire logic [11:0] level,
  input  wire logic        fire,
  output logic             comp_out,
  output logic             trig_out
);
  logic idle_pat;

  initial begin
    idle_pat = 1'b0;
    trig_out = 1'b0;
  end

  // Switched off, the comparator gives junk, so toggle rather than hold
  always @(posedge mclk) begin
    idle_pat <= ~idle_pat;
  end

  assign comp_out = core_en ? (dac_code <= level) : idle_pat;

  // Edge lands off the clock grid, as a real pin would
  always @(posedge fire) begin
    #7 trig_out = 1'b1;
    repeat (4) @(posedge mclk);
    #3 trig_out = 1'b0;
  end
endmodule

// ### sim/sacc_top_bench.sv
/*
  Self-checking bench for the converter control: integer result model,
  clock source, pin isolation, triggers, blocking, compare and aborts.
  Assumes the core model in sacc_core_model; inputs change at falling edges.
*/
`timescale 1ns/1ps
module sacc_top_bench;
  logic                MCLK, RST, SC1_WR, CFG_WR, DONE_CLEAR, RH_READ, RL_READ;
  logic                LOW_POWER, ALT_CLK, HW_TRIG, COMP_IN, CORE_ENABLE, SAMPLE;
  logic                ADCK_TICK, DONE_FLAG, IRQ, BUSY, fire;
  logic [11:0]         CMP_VALUE, DAC_CODE, level;
  logic [15:0]         PIN_CTRL, PORT_IN, PORT_READ, PIN_OUT_DISABLE, PULLUP_DISABLE;
  logic [4:0]          CHANNEL;
  logic [7:0]          RESULT_HIGH, RESULT_LOW;
  sacc_pkg::sacc_cfg_s cfg;
  int                  n_fail, compares, seed;
  logic [15:0]         exp_q[$];

  sacc_top #(.ASYNC_CYCLES(2)) dut (
    .MCLK(MCLK), .RST(RST), .CFG(cfg), .SC1_WR(SC1_WR), .CFG_WR(CFG_WR), .CMP_VALUE(CMP_VALUE),
    .DONE_CLEAR(DONE_CLEAR), .RH_READ(RH_READ), .RL_READ(RL_READ), .LOW_POWER(LOW_POWER),
    .ALT_CLK(ALT_CLK), .HW_TRIG(HW_TRIG), .COMP_IN(COMP_IN), .PIN_CTRL(PIN_CTRL), .PORT_IN(PORT_IN),
    .PORT_READ(PORT_READ), .PIN_OUT_DISABLE(PIN_OUT_DISABLE), .PULLUP_DISABLE(PULLUP_DISABLE),
    .CORE_ENABLE(CORE_ENABLE), .SAMPLE(SAMPLE), .CHANNEL(CHANNEL), .DAC_CODE(DAC_CODE),
    .ADCK_TICK(ADCK_TICK), .RESULT_HIGH(RESULT_HIGH), .RESULT_LOW(RESULT_LOW),
    .DONE_FLAG(DONE_FLAG), .IRQ(IRQ), .BUSY(BUSY));

  sacc_core_model core (.mclk(MCLK), .core_en(CORE_ENABLE), .dac_code(DAC_CODE), .level(level),
    .fire(fire), .comp_out(COMP_IN), .trig_out(HW_TRIG));

  initial begin
    MCLK = 1'b0;
    forever #20 MCLK = ~MCLK;
  end

  // Alternate clock at an unrelated rate and phase
  initial begin
    ALT_CLK = 1'b0;
    #13;
    forever #85 ALT_CLK = ~ALT_CLK;
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    n_fail++;
    test_done();
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge MCLK);
  endtask

  // Pulse kinds: 0 start write, 1 config write, 2 done clear, 3 high read, 4 low read
  task automatic pl(input int k);
    {RL_READ, RH_READ, DONE_CLEAR, CFG_WR, SC1_WR} = 5'(1 << k);
    cyc(1);
    {RL_READ, RH_READ, DONE_CLEAR, CFG_WR, SC1_WR} = 5'h00;
  endtask

  task automatic wait_done();
    int i;
    i = 0;
    while (DONE_FLAG !== 1'b1 && i < 4000) begin
      cyc(1);
      i++;
    end
    if (i >= 4000) begin
      chk("done", 16'(DONE_FLAG), 16'h0001);
    end
  endtask

  // Integer model of the shaped result, saturating after rounding
  function automatic logic [15:0] shape(input logic [1:0] m, input int x);
    int r;
    r = x;
    if (m == sacc_pkg::MODE_10BIT) r = ((x + 2) >> 2) > 1023 ? 1023 : (x + 2) >> 2;
    if (m == sacc_pkg::MODE_8BIT) r = ((x + 8) >> 4) > 255 ? 255 : (x + 8) >> 4;
    return 16'(r);
  endfunction

  // No result reads until done, so nothing is discarded
  task automatic conv(input logic [1:0] m, input logic [11:0] t, input int eg, input bit hw);
    int i;
    cfg.mode = m;
    level = t;
    exp_q.push_back(shape(m, int'(t)));
    if (hw) begin
      // A trigger start leaves the old done standing, so clear it first
      pl(2);
      fire = 1'b1;
      cyc(1);
      fire = 1'b0;
    end else begin
      pl(0);
      chk("sample", 16'(SAMPLE), 16'h0001);
    end
    if (eg > 0) begin
      i = 0;
      while (ADCK_TICK !== 1'b1 && i < 100) begin cyc(1); i++; end
      i = 0;
      do begin cyc(1); i++; end while (ADCK_TICK !== 1'b1 && i < 100);
      chk("tick gap", 16'(i), 16'(eg));
    end
    wait_done();
    chk("result", {RESULT_HIGH, RESULT_LOW}, exp_q.pop_front());
    chk("dac code", 16'(DAC_CODE), 16'(t));
    chk("irq", 16'(IRQ), 16'(cfg.done_interrupt_enable));
    cyc(2);
    chk("busy", 16'({BUSY, CORE_ENABLE}), 16'h0000);
  endtask

  initial begin
    seed = 32'ha47c;
    {RST, SC1_WR, CFG_WR, DONE_CLEAR, RH_READ, RL_READ, LOW_POWER, fire} = 8'h80;
    cfg = '0;
    cfg.channel_select = 5'h03;
    CMP_VALUE = 12'h000;
    level = 12'h000;
    PIN_CTRL = 16'h0000;
    PORT_IN = 16'h0000;
    cyc(3);
    RST = 1'b0;
    chk("reset result", {RESULT_HIGH, RESULT_LOW}, 16'h0000);
    chk("reset channel", 16'({CHANNEL, CORE_ENABLE, DONE_FLAG}), 16'h007C);
    for (int i = 0; i < 4; i++) begin
      PIN_CTRL = 16'($random(seed));
      PORT_IN = 16'($random(seed));
      cyc(3);
      chk("port read", PORT_READ, PORT_IN & ~PIN_CTRL);
      chk("driver off", PIN_OUT_DISABLE, PIN_CTRL);
      chk("pullup off", PULLUP_DISABLE, PIN_CTRL);
    end
    // All three modes; full scale first to reach rounding saturation
    for (int i = 0; i < 9; i++) begin
      cfg.done_interrupt_enable = i[0];
      conv(2'(i % 3), i < 3 ? 12'hFFF : 12'($random(seed)), 0, 0);
    end
    for (int s = 0; s < 2; s++) begin
      for (int d = 0; d < 4; d++) begin
        cfg.clock_source_select = 2'(s);
        cfg.clock_divide_select = 2'(d);
        conv(sacc_pkg::MODE_12BIT, 12'($random(seed)), (1 << d) << s, 0);
      end
    end
    cfg.clock_divide_select = 2'h0;
    cfg.clock_source_select = sacc_pkg::SRC_ASYNC;
    LOW_POWER = 1'b1;
    conv(sacc_pkg::MODE_10BIT, 12'($random(seed)), 2, 0);
    // Bus source must stall in low power and resume on wake
    cfg.clock_source_select = sacc_pkg::SRC_BUS;
    level = 12'h3C5;
    pl(0);
    cyc(25);
    chk("stalled", 16'({DONE_FLAG, BUSY}), 16'h0001);
    LOW_POWER = 1'b0;
    wait_done();
    chk("resumed", {RESULT_HIGH, RESULT_LOW}, 16'h00F1);
    cfg.clock_source_select = sacc_pkg::SRC_ALT;
    conv(sacc_pkg::MODE_12BIT, 12'($random(seed)), 0, 0);
    cfg.clock_source_select = sacc_pkg::SRC_BUS;
    cfg.hw_trigger_enable = 1'b1;
    conv(sacc_pkg::MODE_12BIT, 12'h9C4, 0, 1);
    // Second edge in mid conversion must not start another
    fork
      conv(sacc_pkg::MODE_12BIT, 12'h3B1, 0, 1);
      begin cyc(14); fire = 1'b1; cyc(1); fire = 1'b0; end
    join
    cyc(20);
    chk("busy after edge", 16'(BUSY), 16'h0000);
    cfg.hw_trigger_enable = 1'b0;
    level = 12'h5A3;
    pl(0);
    cyc(3);
    pl(3);
    cyc(4);
    level = 12'h2C7;
    cyc(12);
    chk("blocked done", 16'({DONE_FLAG, BUSY}), 16'h0001);
    chk("blocked result", {RESULT_HIGH, RESULT_LOW}, 16'h03B1);
    pl(4);
    wait_done();
    chk("after block", {RESULT_HIGH, RESULT_LOW}, 16'h02C7);
    cfg.compare_enable = 1'b1;
    cfg.compare_greater = 1'b1;
    CMP_VALUE = 12'h800;
    level = 12'h7FF;
    pl(0);
    cyc(25);
    chk("cmp false", 16'({DONE_FLAG, BUSY}), 16'h0000);
    chk("cmp kept", {RESULT_HIGH, RESULT_LOW}, 16'h02C7);
    conv(sacc_pkg::MODE_12BIT, 12'h800, 0, 0);
    cfg.compare_greater = 1'b0;
    conv(sacc_pkg::MODE_12BIT, 12'h7FF, 0, 0);
    cfg.compare_enable = 1'b0;
    cfg.continuous_enable = 1'b1;
    level = 12'h123;
    pl(0);
    wait_done();
    chk("run first", {RESULT_HIGH, RESULT_LOW}, 16'h0123);
    level = 12'h456;
    for (int i = 0; i < 2; i++) begin
      pl(2);
      wait_done();
    end
    chk("run next", {RESULT_HIGH, RESULT_LOW}, 16'h0456);
    cyc(5);
    pl(1);
    cyc(2);
    chk("abort", 16'({BUSY, DONE_FLAG}), 16'h0000);
    chk("abort kept", {RESULT_HIGH, RESULT_LOW}, 16'h0456);
    cfg.continuous_enable = 1'b0;
    // Two-entry queue: second write starts, entries read back in order
    cfg.fifo_depth = 3'h1;
    level = 12'h6D2;
    cfg.channel_select = 5'h05;
    pl(0);
    cyc(1);
    cfg.channel_select = 5'h06;
    pl(0);
    chk("fifo first", 16'(CHANNEL), 16'h0005);
    cyc(20);
    level = 12'h1E9;
    wait_done();
    chk("fifo last", 16'(CHANNEL), 16'h0006);
    chk("fifo entry 0", {RESULT_HIGH, RESULT_LOW}, 16'h06D2);
    pl(4);
    chk("fifo entry 1", {RESULT_HIGH, RESULT_LOW}, 16'h01E9);
    cfg.fifo_depth = 3'h0;
    cfg.channel_select = 5'h03;
    pl(0);
    cyc(5);
    cfg.channel_select = 5'h1F;
    pl(0);
    cyc(1);
    chk("chan off", 16'({BUSY, CORE_ENABLE}), 16'h0000);
    cfg.channel_select = 5'h03;
    pl(0);
    cyc(5);
    RST = 1'b1;
    cyc(1);
    RST = 1'b0;
    chk("reset abort", {RESULT_HIGH, RESULT_LOW}, 16'h0000);
    chk("reset idle", 16'({BUSY, CORE_ENABLE}), 16'h0000);
    test_done();
  end
endmodule
